// file: pkg/rotate_pkg.sv
/*
 Shared constants and carriers for the accumulator rotate unit.
 Assumes the decoder hands over one whole opcode byte per request.
*/
package rotate_pkg;

   // Opcode encodings of the three rotate instructions
   localparam logic [7:0] OPC_ROTATE_RIGHT_PLAIN     = 8'h03;
   localparam logic [7:0] OPC_ROTATE_RIGHT_VIA_CARRY = 8'h13;
   localparam logic [7:0] OPC_ROTATE_LEFT_VIA_CARRY  = 8'h33;

   // Data widths and reset values
   localparam int         ACC_WIDTH   = 8;
   localparam int         MSB_POS     = 7;
   localparam int         LSB_POS     = 0;
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic       FLAG_RESET  = 1'b0;

   // Timing: one machine cycle of six states, one clock each here
   localparam int         STATES_PER_CYCLE = 6;
   localparam int         OP_LATENCY       = 1;

   typedef enum {
      OP_NONE,
      OP_RIGHT_PLAIN,
      OP_RIGHT_CARRY,
      OP_LEFT_CARRY
   } rotate_op_t;

   // Program status flags touched or preserved by rotates
   typedef struct packed {
      logic carry_flag;
      logic auxiliary_carry_flag;
      logic sign_error_flag;
   } psw_flags_t;

   // Operand bundle from the core
   typedef struct packed {
      logic [7:0] acc;
      psw_flags_t flags;
   } rotate_operand_t;

endpackage : rotate_pkg

// file: src/rotate_decode.sv
/*
 Opcode decoder for the rotate unit: maps one opcode byte to an operation.
 Assumes a full byte from the instruction decoder, same clock, no sync.
*/
`timescale 1ns/1ps
module rotate_decode
   import rotate_pkg::*;
(
   // Opcode in
   input  wire logic [7:0] opcode_in,
   // Decoded operation
   output rotate_op_t      op_out
);

   // Pure combinational decode; unknown opcodes give no operation
   always_comb begin
      case (opcode_in)
         OPC_ROTATE_RIGHT_PLAIN:     op_out = OP_RIGHT_PLAIN;
         OPC_ROTATE_RIGHT_VIA_CARRY: op_out = OP_RIGHT_CARRY;
         OPC_ROTATE_LEFT_VIA_CARRY:  op_out = OP_LEFT_CARRY;
         default:                    op_out = OP_NONE;
      endcase
   end

endmodule : rotate_decode

// file: src/accumulator_rotate_unit.sv
/*
 Accumulator rotate datapath: plain right, right and left through carry.
 Assumes the core presents operand and opcode with a one-cycle strobe and
 writes back the registered result when done_out pulses.
*/
`timescale 1ns/1ps
// Behaviour
// - Plain rotate right moves bits down; old bit 0 lands in bit 7.
// - Opcode 0x03 selects the plain rotate right.
// - Right via carry rotates the nine-bit accumulator-plus-carry ring down.
// - Right via carry loads carry from old accumulator bit 0.
// - Right via carry puts the old carry into accumulator bit 7.
// - Opcode 0x33 selects rotate left via carry.
// - Left via carry shifts up, old carry to bit 0, bit 7 to carry.
// - Left via carry rotates the nine-bit ring toward the top.
module accumulator_rotate_unit
   import rotate_pkg::*;
(
   // Clock and reset
   input  wire logic             clock_in,
   input  wire logic             reset_in,
   // Request from the decoder
   input  wire logic             start_in,
   input  wire logic [7:0]       opcode_in,
   input  wire rotate_operand_t  operand_in,
   // Result to accumulator and status word
   output logic                  done_out,
   output logic                  hit_out,
   output rotate_operand_t       result_out
);

   typedef struct packed {
      logic            done;
      logic            hit;
      rotate_operand_t result;
   } state_t;

   state_t     state;
   state_t     next_state;
   rotate_op_t op;
   logic [8:0] ring;
   logic [7:0] lane_down;
   logic [7:0] lane_up;
   logic [7:0] right_plain_acc;
   logic [7:0] right_carry_acc;
   logic [7:0] left_carry_acc;
   logic       right_carry_out;
   logic       left_carry_out;

   // Plain right rotate: the ring is only the eight accumulator bits
   function automatic logic [7:0] wrap_right_plain(
      input logic [7:0] shifted,
      input logic [7:0] value
   );
      logic [7:0] rotated;
      rotated         = shifted;
      rotated[MSB_POS] = value[LSB_POS];
      return rotated;
   endfunction : wrap_right_plain

   // Right through carry: old carry refills the top bit
   function automatic logic [7:0] wrap_right_carry(
      input logic [7:0] shifted,
      input logic       carry
   );
      logic [7:0] rotated;
      rotated          = shifted;
      rotated[MSB_POS] = carry;
      return rotated;
   endfunction : wrap_right_carry

   // Left through carry: old carry refills the bottom bit
   function automatic logic [7:0] wrap_left_carry(
      input logic [7:0] shifted,
      input logic       carry
   );
      logic [7:0] rotated;
      rotated          = shifted;
      rotated[LSB_POS] = carry;
      return rotated;
   endfunction : wrap_left_carry

   // Carry leaving the ring: the bit pushed off the chosen end
   function automatic logic carry_leaving(
      input logic [7:0] value,
      input logic       toward_top
   );
      logic leaving;
      leaving = value[LSB_POS];
      if (toward_top) begin
         leaving = value[MSB_POS];
      end
      return leaving;
   endfunction : carry_leaving

   rotate_decode decoder (
      .opcode_in (opcode_in),
      .op_out    (op)
   );

   // Nine-bit ring: carry above the accumulator
   assign ring = {operand_in.flags.carry_flag, operand_in.acc};

   // Shared shift lanes; the wrap bits are filled in per instruction.
   // One lane pair serves all three rotates: both right rotates share lane_down
   // and differ only in the bit 7 fill; left via carry uses lane_up.
   for (genvar bit_idx = 0; bit_idx < ACC_WIDTH; bit_idx++) begin : g_lane
      if (bit_idx == MSB_POS) begin : g_top
         assign lane_down[bit_idx] = 1'b0;        // Refilled by wrap
         assign lane_up[bit_idx]   = operand_in.acc[bit_idx - 1];
      end else if (bit_idx == LSB_POS) begin : g_bottom
         assign lane_down[bit_idx] = operand_in.acc[bit_idx + 1];
         assign lane_up[bit_idx]   = 1'b0;        // Refilled by wrap
      end else begin : g_middle
         assign lane_down[bit_idx] = operand_in.acc[bit_idx + 1];
         assign lane_up[bit_idx]   = operand_in.acc[bit_idx - 1];
      end
   end

   // Candidate results for each rotate, computed every cycle
   assign right_plain_acc = wrap_right_plain(lane_down,
                                             operand_in.acc);
   assign right_carry_acc = wrap_right_carry(lane_down,
                                             ring[8]);
   assign left_carry_acc  = wrap_left_carry(lane_up,
                                            ring[8]);
   assign right_carry_out = carry_leaving(operand_in.acc, 1'b0);
   assign left_carry_out  = carry_leaving(operand_in.acc, 1'b1);

   // Result in one cycle; flags copied through unless carry is rotated
   always_comb begin
      next_state             = state;
      next_state.done        = start_in;
      next_state.hit         = 1'b0;
      if (start_in) begin
         next_state.result   = operand_in;
         next_state.hit      = (op != OP_NONE);
         case (op)
            OP_RIGHT_PLAIN: begin
               // Carry stays as copied from the operand
               next_state.result.acc = right_plain_acc;
            end
            OP_RIGHT_CARRY: begin
               // Ring rotated down: bit 0 wraps into the carry slot
               next_state.result.acc = right_carry_acc;
               next_state.result.flags.carry_flag =
                  right_carry_out;
            end
            OP_LEFT_CARRY: begin
               // Ring rotated up: carry wraps into bit 0
               next_state.result.acc = left_carry_acc;
               next_state.result.flags.carry_flag =
                  left_carry_out;
            end
            default: begin
               // Not a rotate: pass operand back unchanged
               next_state.result = operand_in;
            end
         endcase
      end
   end

   // Single state register; synchronous reset
   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         state <= '{done: 1'b0, hit: 1'b0,
                    result: '{acc: ACC_RESET,
                              flags: '{FLAG_RESET, FLAG_RESET,
                                       FLAG_RESET}}};
      end else begin
         state <= next_state;
      end
   end

   // Outputs straight from flops
   assign done_out   = state.done;
   assign hit_out    = state.hit;
   assign result_out = state.result;

endmodule : accumulator_rotate_unit

// file: tb/rotate_properties.sv
/* Port checker for the rotate unit. Assumes one clock, sync reset. */
`timescale 1ns/1ps
module rotate_checker import rotate_pkg::*; (
   // Watched ports
   input wire logic clock_in, reset_in, start_in, done_out, hit_out,
   input wire logic [7:0] opcode_in,
   input wire rotate_operand_t operand_in, result_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   // Operand and result views, decoded strobes
   wire [7:0] a = operand_in.acc, q = result_out.acc;
   wire c = operand_in.flags.carry_flag, k = result_out.flags.carry_flag;
   wire rr = start_in && opcode_in == OPC_ROTATE_RIGHT_PLAIN;
   wire rc = start_in && opcode_in == OPC_ROTATE_RIGHT_VIA_CARRY;
   wire lc = start_in && opcode_in == OPC_ROTATE_LEFT_VIA_CARRY;
   a_right_plain: assert property (rr |=>
      q == {$past(a[0]), $past(a[7:1])} && k == $past(c)) else $error("rr");
   a_right_carry: assert property (rc |=>
      q == {$past(c), $past(a[7:1])} && k == $past(a[0])) else $error("rc");
   a_left_carry: assert property (lc |=>
      q == {$past(a[6:0]), $past(c)} && k == $past(a[7])) else $error("lc");
   a_flags_kept: assert property (start_in |=>
      result_out.flags[1:0] == $past(operand_in.flags[1:0])) else $error("f");
   a_done_next: assert property (start_in |=> done_out) else $error("d");
   a_done_idle: assert property (!start_in |=> !done_out) else $error("i");
   a_hit_code: assert property (start_in |=>
      hit_out == $past(rr || rc || lc)) else $error("h");
   a_hit_done: assert property (hit_out |-> done_out) else $error("hd");
   // Each rotate kind reached
   cover property (rr);
   cover property (rc);
   cover property (lc);
endmodule : rotate_checker
bind accumulator_rotate_unit rotate_checker i_chk (.clock_in(clock_in),
   .reset_in(reset_in), .start_in(start_in), .done_out(done_out),
   .hit_out(hit_out), .opcode_in(opcode_in), .operand_in(operand_in),
   .result_out(result_out));

// file: tb/core_acc_model.sv
/* Core accumulator and status word; bench reloads or result writes back. */
`timescale 1ns/1ps
module core_acc_model import rotate_pkg::*; (
   input  wire logic            clock_in,
   input  wire logic            load_in,
   input  wire logic            done_in,
   input  wire rotate_operand_t load_val_in,
   input  wire rotate_operand_t result_in,
   output rotate_operand_t      acc_out
);
   // Write-back keeps chains of rotates on one accumulator
   always_ff @(posedge clock_in)
      if (load_in) acc_out <= load_val_in;
      else if (done_in) acc_out <= result_in;
endmodule : core_acc_model

// file: tb/tb.sv
/* Random rotates against an integer model. Needs the partner model. */
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", n, e, s); end end
module tb import rotate_pkg::*;;
   logic clock_in = 0, reset_in = 1, start_in = 0, load = 1, done, hit;
   logic [7:0] opcode_in = 8'h00, ops [4] = '{8'h03, 8'h13, 8'h33, 8'h00};
   logic [31:0] seed = 32'hC8885115;
   rotate_operand_t load_val = '0, operand, result;
   int n_fail = 0, cmp_count = 0, e, q[$];
   accumulator_rotate_unit i_accumulator_rotate_unit (.clock_in(clock_in),
      .reset_in(reset_in), .start_in(start_in), .opcode_in(opcode_in),
      .operand_in(operand), .done_out(done), .hit_out(hit), .result_out(result));
   core_acc_model i_core_acc_model (.clock_in(clock_in), .load_in(load),
      .done_in(done), .load_val_in(load_val), .result_in(result),
      .acc_out(operand));
   // Hit in bit 11, then acc, carry, aux carry, sign error
   function automatic int model(int op, int v);
      int a = v >> 3, c = v >> 2 & 1, h = 1;
      case (op)
         'h03: a = a >> 1 | (a & 1) << 7;
         'h13: begin a = a | c << 8; c = a & 1; a = a >> 1; end
         'h33: begin a = a << 1 | c; c = a >> 8; a = a & 255; end
         default: h = 0;
      endcase
      return h << 11 | a << 3 | c << 2 | v & 3;
   endfunction : model
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ s << 5;
   endfunction : xs
   task stop_test;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   initial forever #50 clock_in = ~clock_in;
   // Queue each taken request, compare each answer a cycle later
   always @(posedge clock_in) if (!reset_in) begin
      `CHK("done", q.size() > 0, done)
      if (done) begin
         e = q.pop_front();
         `CHK("result", e, {hit, result})
      end
      if (start_in) q.push_back(model(opcode_in, operand));
   end
   initial begin
      repeat (8) @(posedge clock_in);
      reset_in <= 0;
      @(posedge clock_in);
      `CHK("reset", 0, {done, hit, result})
      $display("reset test done");
      repeat (2000) begin
         seed = xs(seed);
         ops[3] = seed[31:24];
         start_in <= seed[0] | seed[1];
         opcode_in <= ops[seed[3:2]];
         load <= seed[4];
         load_val <= seed[15:5];
         @(posedge clock_in);
      end
      start_in <= 0;
      repeat (2) @(posedge clock_in);
      $display("random test done");
      stop_test;
   end
   // Run needs about 2011 cycles
   initial begin
      #(100 * 2200);
      n_fail++;
      stop_test;
   end
endmodule : tb
